// [verilog/analog_comparator_control.sv]
// register, edge detection and interrupt logic around the analog comparator core
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module analog_comparator_control (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    input wire logic comparator_raw,
    output logic comparator_power_enable,
    output logic reference_select,
    output logic comparator_output_pin,
    output logic comparator_output_pin_oe_n,
    input wire logic stop_mode,
    input wire logic deep_stop_wake,
    output logic wake_request
);

    positive_analog_input_pkg::ctrl_type ctrl_q, ctrl_d;
    positive_analog_input_pkg::bus_state_type state_q, state_d;
    logic [31:0] readdata_q, readdata_d;
    logic [positive_analog_input_pkg::status_width-1:0] status_q, status_d;
    logic [positive_analog_input_pkg::status_width-1:0] mask_q, mask_d;
    logic sync1_q, sync2_q, prev_q, run_q;
    logic block_rst;

    function automatic logic event_hit(
        input logic [positive_analog_input_pkg::mode_width-1:0] mode,
        input positive_analog_input_pkg::edge_type edges
    );
        case (mode)
            positive_analog_input_pkg::mode_fall_a: event_hit = edges.fall;
            positive_analog_input_pkg::mode_rise: event_hit = edges.rise;
            positive_analog_input_pkg::mode_fall_b: event_hit = edges.fall;
            positive_analog_input_pkg::mode_toggle: event_hit = edges.rise | edges.fall;
            default: event_hit = 1'b0;
        endcase
    endfunction : event_hit

    // deep-stop wake-up acts like a reset of the whole block
    assign block_rst = rst | deep_stop_wake;

    // bus decode
    wire req = read | write;
    wire acc = (state_q == positive_analog_input_pkg::bus_ack);
    wire wr_fire = write & acc & byteenable[0];
    wire rd_fire = read & acc;
    wire sel_ctrl = (address == positive_analog_input_pkg::ctrl_offset);
    wire sel_status = (address == positive_analog_input_pkg::irq_status_offset);
    wire sel_mask = (address == positive_analog_input_pkg::irq_mask_offset);
    wire wr_ctrl = wr_fire & sel_ctrl;
    wire wr_mask = wr_fire & sel_mask;
    wire rd_status = rd_fire & sel_status;
    wire flag_clear = wr_ctrl & writedata[positive_analog_input_pkg::flag_bit];
    wire positive_analog_input_pkg::ctrl_type wr_val = positive_analog_input_pkg::ctrl_type'(writedata[7:0]);

    assign waitrequest = req & ~acc;
    assign readdata = readdata_q;

    // comparator side
    assign comparator_power_enable = ctrl_q.enable;
    assign reference_select = ctrl_q.ref_select;
    // the minus pin is hard-wired to the inverting input in the core

    // edges are taken only after a full cycle enabled; a result already high at turn-on still shows as a rising edge two cycles later
    wire positive_analog_input_pkg::edge_type edges = '{
        rise: run_q & ctrl_q.enable & sync2_q & ~prev_q,
        fall: run_q & ctrl_q.enable & ~sync2_q & prev_q
    };
    wire event_now = event_hit(ctrl_q.mode, edges);

    wire live_value = ctrl_q.enable & sync2_q;

    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d.enable = wr_val.enable;
            ctrl_d.ref_select = wr_val.ref_select;
            ctrl_d.irq_enable = wr_val.irq_enable;
            ctrl_d.pin_enable = wr_val.pin_enable;
            ctrl_d.mode = wr_val.mode;
        end
        // set wins over a clear in the same cycle
        ctrl_d.flag = event_now | (ctrl_q.flag & ~flag_clear);
        ctrl_d.output_value = live_value;
    end

    wire [positive_analog_input_pkg::status_width-1:0] status_clr =
        rd_status ? readdata_q[positive_analog_input_pkg::status_width-1:0] : '0;
    // only bits the host actually saw are cleared by the read
    assign status_d = {event_now} | (status_q & ~status_clr);
    assign mask_d = wr_mask ? writedata[positive_analog_input_pkg::status_width-1:0] : mask_q;

    always_comb begin
        case (state_q)
            positive_analog_input_pkg::bus_idle: state_d = req ? positive_analog_input_pkg::bus_ack : positive_analog_input_pkg::bus_idle;
            positive_analog_input_pkg::bus_ack: state_d = positive_analog_input_pkg::bus_idle;
            default: state_d = positive_analog_input_pkg::bus_idle;
        endcase
    end

    wire [31:0] rd_ctrl_word = {24'h000000, ctrl_q};
    wire [31:0] rd_status_word = {{(32 - positive_analog_input_pkg::status_width){1'b0}}, status_q};
    wire [31:0] rd_mask_word = {{(32 - positive_analog_input_pkg::status_width){1'b0}}, mask_q};
    wire [31:0] rd_word = sel_ctrl ? rd_ctrl_word :
                          sel_status ? rd_status_word :
                          sel_mask ? rd_mask_word : 32'h00000000;
    assign readdata_d = (read & ~acc) ? rd_word : readdata_q;

    always_ff @(posedge clock) begin
        if (block_rst) begin
            ctrl_q <= positive_analog_input_pkg::ctrl_type'(positive_analog_input_pkg::ctrl_reset);
            status_q <= positive_analog_input_pkg::irq_status_reset;
            mask_q <= positive_analog_input_pkg::irq_mask_reset;
            state_q <= positive_analog_input_pkg::bus_idle;
            readdata_q <= 32'h00000000;
        end else begin
            ctrl_q <= ctrl_d;
            status_q <= status_d;
            mask_q <= mask_d;
            state_q <= state_d;
            readdata_q <= readdata_d;
        end
    end

    // synchroniser for the asynchronous comparator result
    always_ff @(posedge clock) begin
        if (block_rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            sync1_q <= comparator_raw;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            run_q <= ctrl_q.enable;
        end
    end

    wire flag_irq = ctrl_q.irq_enable & ctrl_q.flag;
    assign irq = flag_irq | (|(status_q & mask_q));
    assign wake_request = stop_mode & flag_irq;

    assign comparator_output_pin = ctrl_q.pin_enable & ctrl_q.output_value;
    assign comparator_output_pin_oe_n = ~ctrl_q.pin_enable;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (block_rst);

    a_disabled_quiet: assert property (
        !ctrl_q.enable |-> !live_value && !event_now && !comparator_power_enable)
        else $error("disabled comparator produced activity");

    a_power_follows_enable: assert property (
        comparator_power_enable == ctrl_q.enable)
        else $error("power enable differs from enable bit");

    a_enable_no_event: assert property (
        $rose(ctrl_q.enable) |-> !event_now)
        else $error("turning on produced an event");

    a_ref_select_write: assert property (
        wr_ctrl |=> reference_select == $past(writedata[positive_analog_input_pkg::ref_select_bit]))
        else $error("reference select did not follow write");

    a_ref_select_stable: assert property (
        !wr_ctrl |=> $stable(reference_select))
        else $error("reference select moved without write");

    a_flag_sets_event: assert property (
        event_now |=> ctrl_q.flag)
        else $error("event did not set flag");

    a_flag_only_event: assert property (
        $rose(ctrl_q.flag) |-> $past(event_now))
        else $error("flag set without event");

    a_flag_w1c_clear: assert property (
        ctrl_q.flag && flag_clear && !event_now |=> !ctrl_q.flag)
        else $error("write one did not clear flag");

    a_flag_holds_set: assert property (
        ctrl_q.flag && !flag_clear |=> ctrl_q.flag)
        else $error("flag dropped without a clear");

    a_flag_stays_clear: assert property (
        !ctrl_q.flag && !event_now |=> !ctrl_q.flag)
        else $error("flag rose without an event");

    a_flag_set_priority: assert property (
        event_now && flag_clear |=> ctrl_q.flag)
        else $error("clear beat a simultaneous set");

    a_irq_from_flag: assert property (
        ctrl_q.irq_enable && ctrl_q.flag |-> irq)
        else $error("flag with enable gave no interrupt");

    a_irq_held_off: assert property (
        (!ctrl_q.irq_enable && mask_q == '0) |-> !irq)
        else $error("interrupt without enable");

    a_irq_needs_flag: assert property (
        !ctrl_q.flag && (status_q & mask_q) == '0 |-> !irq)
        else $error("interrupt without a pending flag");

    a_status_event_set: assert property (
        event_now |=> status_q[positive_analog_input_pkg::event_status_bit])
        else $error("event did not set status bit");

    a_status_read_clear: assert property (
        rd_status && readdata_q[positive_analog_input_pkg::event_status_bit] && !event_now |=> !status_q[positive_analog_input_pkg::event_status_bit])
        else $error("status read did not clear bit");

    a_mask_write_lands: assert property (
        wr_mask |=> mask_q == $past(writedata[positive_analog_input_pkg::status_width-1:0]))
        else $error("mask did not follow write");

    a_output_read_zero: assert property (
        !ctrl_q.enable ##1 !ctrl_q.enable |-> !ctrl_q.output_value)
        else $error("output bit not zero while disabled");

    a_output_tracks_live: assert property (
        ctrl_q.enable |=> ctrl_q.output_value == $past(sync2_q))
        else $error("output bit lags comparator");

    a_output_read_only: assert property (
        wr_ctrl |=> ctrl_q.output_value == $past(live_value))
        else $error("write reached the output bit");

    a_pin_gated: assert property (
        !ctrl_q.pin_enable |-> comparator_output_pin_oe_n && !comparator_output_pin)
        else $error("result on pin while pin disabled");

    a_pin_drives_value: assert property (
        ctrl_q.pin_enable |-> !comparator_output_pin_oe_n && comparator_output_pin == ctrl_q.output_value)
        else $error("pin does not show comparator result");

    a_mode_rise_only: assert property (
        ctrl_q.mode == positive_analog_input_pkg::mode_rise && edges.fall |-> !event_now)
        else $error("falling edge counted in rising mode");

    a_mode_rise_hit: assert property (
        ctrl_q.mode == positive_analog_input_pkg::mode_rise && edges.rise |-> event_now)
        else $error("rising edge missed in rising mode");

    a_mode_fall_only: assert property (
        (ctrl_q.mode == positive_analog_input_pkg::mode_fall_a || ctrl_q.mode == positive_analog_input_pkg::mode_fall_b) && edges.rise |-> !event_now)
        else $error("rising edge counted in falling mode");

    a_mode_fall_hit: assert property (
        (ctrl_q.mode == positive_analog_input_pkg::mode_fall_a || ctrl_q.mode == positive_analog_input_pkg::mode_fall_b) && edges.fall |-> event_now)
        else $error("falling edge missed in falling mode");

    a_mode_toggle_both: assert property (
        ctrl_q.mode == positive_analog_input_pkg::mode_toggle && (edges.rise || edges.fall) |-> event_now)
        else $error("edge missed in toggle mode");

    a_rise_polarity: assert property (
        edges.rise |-> sync2_q && !prev_q && ctrl_q.enable)
        else $error("rising edge with wrong polarity");

    a_fall_polarity: assert property (
        edges.fall |-> !sync2_q && prev_q && ctrl_q.enable)
        else $error("falling edge with wrong polarity");

    a_readdata_upper_zero: assert property (
        read && !waitrequest |-> readdata[31:8] == 24'h000000)
        else $error("upper read data bits not zero");

    a_sync_two_stage: assert property (
        !block_rst ##1 !block_rst ##1 !block_rst |-> sync2_q == $past(comparator_raw, 2))
        else $error("synchroniser depth wrong");

    a_wake_in_stop: assert property (
        stop_mode && event_now && ctrl_q.irq_enable && !wr_ctrl ##1 stop_mode |-> wake_request)
        else $error("no wake-up on event in stop");

    a_wake_only_stop: assert property (
        !stop_mode |-> !wake_request)
        else $error("wake-up outside stop");

    a_deep_wake_reset: assert property (@(posedge clock) disable iff (rst)
        deep_stop_wake |=> ctrl_q == positive_analog_input_pkg::ctrl_type'(positive_analog_input_pkg::ctrl_reset) && mask_q == '0)
        else $error("registers not reset after deep wake-up");

    a_bus_one_wait: assert property (
        req && !acc |=> !waitrequest || !req)
        else $error("bus answer took more than one wait cycle");

    a_ack_one_cycle: assert property (
        acc |=> !acc)
        else $error("acknowledge held longer than one cycle");

endmodule : analog_comparator_control

`default_nettype wire

// [verilog/positive_analog_input_pkg.sv]
// constants, register layout and types of the analog comparator control block
package positive_analog_input_pkg;

    localparam logic [3:0] ctrl_offset = 4'h0;
    localparam logic [3:0] irq_status_offset = 4'h4;
    localparam logic [3:0] irq_mask_offset = 4'h8;

    localparam int enable_bit = 7;
    localparam int ref_select_bit = 6;
    localparam int flag_bit = 5;
    localparam int irq_enable_bit = 4;
    localparam int output_value_bit = 3;
    localparam int pin_enable_bit = 2;
    localparam int mode_lsb = 0;
    localparam int mode_width = 2;

    localparam int event_status_bit = 0;
    localparam int status_width = 1;

    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [status_width-1:0] irq_status_reset = 1'h0;
    localparam logic [status_width-1:0] irq_mask_reset = 1'h0;

    localparam logic [mode_width-1:0] mode_fall_a = 2'h0;
    localparam logic [mode_width-1:0] mode_rise = 2'h1;
    localparam logic [mode_width-1:0] mode_fall_b = 2'h2;
    localparam logic [mode_width-1:0] mode_toggle = 2'h3;

    typedef struct packed {
        logic enable;
        logic ref_select;
        logic flag;
        logic irq_enable;
        logic output_value;
        logic pin_enable;
        logic [mode_width-1:0] mode;
    } ctrl_type;

    typedef struct packed {
        logic rise;
        logic fall;
    } edge_type;

    typedef enum logic [1:0] {
        bus_idle = 2'b01,
        bus_ack = 2'b10
    } bus_state_type;

endpackage : positive_analog_input_pkg

// [bench/comparator_core_model.sv]
// behavioural analog comparator core facing the control block
`timescale 1ns/1ps
`default_nettype none
module comparator_core_model (
    input wire logic power_enable,
    input wire logic reference_select,
    input wire logic [7:0] plus_level,
    input wire logic [7:0] minus_level,
    input wire logic [7:0] bandgap_level,
    output logic raw
);
    wire logic [7:0] noninv = reference_select ? bandgap_level : plus_level;
    // minus level always feeds the inverting side; result is low while unpowered
    assign raw = power_enable & (noninv > minus_level);
endmodule : comparator_core_model
`default_nettype wire

// [bench/analog_comparator_control_test.sv]
// self-checking testbench of the analog comparator control block
`timescale 1ns/1ps
`default_nettype none
module analog_comparator_control_test;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hf;
    logic stop_mode = 1'b0;
    logic deep_stop_wake = 1'b0;
    logic [7:0] plus_level = 8'h10;
    logic [7:0] minus_level = 8'h80;
    logic [7:0] bandgap_level = 8'hc0;
    logic [31:0] readdata, data_seen;
    logic waitrequest, irq, raw, power_en, ref_sel, pin, pin_oe_n, wake, wait_seen;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;

    analog_comparator_control analog_comparator_control_i (.clock(clock), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .comparator_raw(raw), .comparator_power_enable(power_en),
        .reference_select(ref_sel), .comparator_output_pin(pin), .comparator_output_pin_oe_n(pin_oe_n),
        .stop_mode(stop_mode), .deep_stop_wake(deep_stop_wake), .wake_request(wake));
    comparator_core_model comparator_core_model_i (.power_enable(power_en), .reference_select(ref_sel),
        .plus_level(plus_level), .minus_level(minus_level), .bandgap_level(bandgap_level), .raw(raw));

    initial begin
        forever #25 clock = ~clock;
    end
    // bus answers are settled before the falling edge and used at the next rising edge
    always @(negedge clock) begin
        wait_seen = waitrequest;
        data_seen = readdata;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        comparisons++;
        if (seen !== expected) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask : check

    task automatic bus(input logic [3:0] addr, input logic rd_n_wr, input logic [7:0] data);
        address <= addr;
        read <= rd_n_wr;
        write <= !rd_n_wr;
        writedata <= {24'h0, data};
        // only the global cycle ceiling ends a wait that never completes
        do begin
            @(posedge clock);
        end while (wait_seen !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask : bus

    task automatic wr(input logic [3:0] addr, input logic [7:0] data);
        bus(addr, 1'b0, data);
    endtask : wr

    task automatic rd(input logic [3:0] addr, input logic [7:0] expected);
        bus(addr, 1'b1, 8'h00);
        check(data_seen, {24'h0, expected});
    endtask : rd

    task automatic settle(input logic [7:0] level);
        plus_level <= level;
        repeat (6) @(posedge clock);
    endtask : settle

    task automatic t_reset;
        rd(4'h0, 8'h00);
        rd(4'h4, 8'h00);
        rd(4'hc, 8'h00);
        check({pin_oe_n, power_en}, 2'b10);
        check(waitrequest, 1'b0);
    endtask : t_reset

    task automatic t_select;
        wr(4'h0, 8'hc0);
        check(ref_sel, 1'b1);
        settle(8'h10);
        rd(4'h0, 8'hc8);
        // back to the plus pin, below the minus level: a falling edge in mode 00
        wr(4'h0, 8'h80);
        settle(8'h10);
        rd(4'h0, 8'ha0);
        check(power_en, 1'b1);
    endtask : t_select

    task automatic t_modes;
        for (int i = 0; i < 4; i++) begin
            wr(4'h0, 8'ha0 | i[7:0]);
            settle(8'hf0);
            rd(4'h0, 8'h88 | {2'h0, i[0], 5'h0} | i[7:0]);
            wr(4'h0, 8'ha0 | i[7:0]);
            rd(4'h0, 8'h88 | i[7:0]);
            settle(8'h10);
            rd(4'h0, 8'h80 | {2'h0, i != 1, 5'h0} | i[7:0]);
        end
    endtask : t_modes

    task automatic t_irq;
        wr(4'h0, 8'hb1);
        check(irq, 1'b0);
        settle(8'hf0);
        check(irq, 1'b1);
        wr(4'h0, 8'ha1);
        check(irq, 1'b0);
        wr(4'h8, 8'h01);
        check(irq, 1'b1);
        rd(4'h4, 8'h01);
        check(irq, 1'b0);
        wr(4'h8, 8'h00);
        byteenable <= 4'h0;
        wr(4'h8, 8'h01);
        byteenable <= 4'hf;
        rd(4'h8, 8'h00);
        settle(8'h10);
    endtask : t_irq

    task automatic t_pin;
        wr(4'h0, 8'ha4);
        settle(8'hf0);
        check({pin, pin_oe_n}, 2'b10);
        wr(4'h0, 8'h80);
        check({pin, pin_oe_n}, 2'b01);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h00);
        check(power_en, 1'b0);
        settle(8'h10);
    endtask : t_pin

    task automatic t_stop;
        stop_mode <= 1'b1;
        wr(4'h0, 8'hb3);
        settle(8'hf0);
        check(wake, 1'b1);
        deep_stop_wake <= 1'b1;
        @(posedge clock);
        deep_stop_wake <= 1'b0;
        stop_mode <= 1'b0;
        @(posedge clock);
        rd(4'h0, 8'h00);
        check(wake, 1'b0);
    endtask : t_stop

    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_select();
        t_modes();
        t_irq();
        t_pin();
        t_stop();
        summarize();
    end
endmodule : analog_comparator_control_test
`default_nettype wire
